// >>> pkg/pwm12_pkg.sv
// Purpose: Shared constants for the cascaded PWM / PPG timer
// Assumes: Byte-wide register port, addresses as printed where given
// Notes:   Field positions refer to the timer mode and run registers
`default_nettype none
package pwm12_pkg;
  // Register addresses
  localparam logic [7:0] DUTY_LOW_ADDR    = 8'h28;
  localparam logic [7:0] DUTY_HIGH_ADDR   = 8'h29;
  localparam logic [7:0] MODE_ADDR        = 8'h2A;
  localparam logic [7:0] RUN_ADDR         = 8'h2B;
  localparam logic [7:0] PERIOD_LOW_ADDR  = 8'h2C;
  localparam logic [7:0] PERIOD_HIGH_ADDR = 8'h2D;
  localparam logic [7:0] STATUS_ADDR      = 8'h2E;

  // Timer mode and run register fields
  localparam int CLK_SEL_LSB = 0;
  localparam int CLK_SEL_MSB = 2;
  localparam int DBE_BIT     = 3;
  localparam int TFF_BIT     = 4;
  localparam int MODE_LSB    = 5;
  localparam int MODE_MSB    = 6;
  localparam int SLOW_BIT    = 7;
  localparam int RUN_BIT     = 0;

  localparam logic [1:0] MODE_PWM12 = 2'h2;
  localparam logic [1:0] MODE_PPG16 = 2'h3;

  // Reset values
  localparam logic [7:0]  DUTY_RESET   = 8'hFF;
  localparam logic [7:0]  PERIOD_RESET = 8'hFF;
  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam logic [15:0] CNT_RESET    = 16'h0000;
  localparam logic [3:0]  FRAME_RESET  = 4'h0;

  // Source clock dividers, as power-of-two exponents
  localparam logic [3:0] GEAR_EXP_0 = 4'hB;
  localparam logic [3:0] GEAR_EXP_1 = 4'hA;
  localparam logic [3:0] GEAR_EXP_2 = 4'h8;
  localparam logic [3:0] GEAR_EXP_3 = 4'h6;
  localparam logic [3:0] GEAR_EXP_4 = 4'h4;
  localparam logic [3:0] GEAR_EXP_5 = 4'h2;
  localparam logic [3:0] GEAR_EXP_6 = 4'h1;
  localparam logic [3:0] GEAR_EXP_7 = 4'h0;
  localparam logic [2:0] SLOW_EXP_0 = 3'h4;
  localparam logic [2:0] SLOW_EXP_1 = 3'h3;
  localparam logic [2:0] SLOW_EXP_7 = 3'h2;

  // Frame positions of the extra pulse bits (frame index = cycle - 1)
  localparam logic [3:0] XP0_FRAME = 4'h8;
  localparam logic [2:0] XP1_FRAME = 3'h4;
  localparam logic [1:0] XP2_FRAME = 2'h2;
  localparam logic       XP3_FRAME = 1'h1;

  localparam logic [7:0] PWM_TOP    = 8'hFF;
  localparam logic [3:0] FRAME_LAST = 4'hF;
endpackage
`default_nettype wire

// >>> rtl/pwm12_duty_double_buffer.sv
// Purpose: 12-bit PWM and 16-bit PPG timer with double-buffered duty
// Assumes: Gear clock is core_clk; low_freq_clock is an asynchronous pin
// Notes:   Register writes to the mode register are ignored while running
//
// Summary of operation
// - Buffered running write goes only to buffer; matching keeps old duty
// - Every sixteenth PWM overflow, or every PPG period end, raises sixteen-cycle irq and copies buffer in
// - Duty reads return the buffered value committed by the last high write
// - Buffered write while stopped loads buffer and active duty at once
// - Unbuffered write updates active duty at once, running or stopped
// - New duty below count: no toggle until overflow and later match
// - New duty equal to count matches right after the write
// - Three-bit select picks gear divider or slow clock divider
// - PPG mode: 16-bit counter against 16-bit period and duty
// - Low register written first; high write commits both together
// - Extra pulse bits lengthen duty in fixed cycles of sixteen
// - Low byte match toggles output; overflow at 256 toggles back
// - Clearing run stops and clears counter, output to initial level
`timescale 1ns/100ps
`default_nettype none
module pwm12_duty_double_buffer (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  input  wire logic       low_freq_clock,
  output var  logic       pwm_output_pin,
  output var  logic       overflow_irq,
  output var  logic       sixteen_cycle_irq
);

  function automatic logic gear_tick(input logic [10:0] cnt, input logic [3:0] exp);
    logic [10:0] m;
    m = ~(11'h7FF << exp);
    return (cnt & m) == m;
  endfunction

  function automatic logic slow_tick(input logic [3:0] cnt, input logic [2:0] exp);
    logic [3:0] m;
    m = ~(4'hF << exp);
    return (cnt & m) == m;
  endfunction

  function automatic logic extra_here(input logic [3:0] pat, input logic [3:0] frame);
    return (pat[0] & (frame == pwm12_pkg::XP0_FRAME)) |
           (pat[1] & (frame[2:0] == pwm12_pkg::XP1_FRAME)) |
           (pat[2] & (frame[1:0] == pwm12_pkg::XP2_FRAME)) |
           (pat[3] & (frame[0] == pwm12_pkg::XP3_FRAME));
  endfunction

  logic [7:0]  timer_mode_q;
  logic        run_q;
  logic [7:0]  duty_low_q;
  logic [7:0]  period_low_q;
  logic [7:0]  period_high_q;
  logic [15:0] dbuf_duty_q;
  logic [15:0] dbuf_period_q;
  logic [15:0] active_duty_q;
  logic [15:0] active_period_q;
  logic [15:0] cnt_q;
  logic [3:0]  frame_q;
  logic        dmatched_q;
  logic [10:0] gear_q;
  logic [3:0]  slow_div_q;
  logic        lf_s1_q;
  logic        lf_s2_q;
  logic        lf_s3_q;
  logic        lf_level_q;
  logic        lf_edge;
  logic [2:0]  source_clock_select;
  logic        double_buffer_enable;
  logic        output_initial_level;
  logic        slow_clock_route_select;
  logic [1:0]  mode;
  logic        pwm_mode;
  logic        ppg_mode;
  logic        running;
  logic [3:0]  gear_exp;
  logic [2:0]  slow_exp;
  logic        use_slow;
  logic        tick;
  logic [7:0]  duty_width;
  logic [3:0]  extra_pulse_pattern;
  logic [8:0]  pwm_target;
  logic        duty_hit;
  logic        period_end;
  logic        transfer;
  logic        commit;
  logic        direct;
  assign source_clock_select     = timer_mode_q[pwm12_pkg::CLK_SEL_MSB:pwm12_pkg::CLK_SEL_LSB];
  assign double_buffer_enable    = timer_mode_q[pwm12_pkg::DBE_BIT];
  assign output_initial_level    = timer_mode_q[pwm12_pkg::TFF_BIT];
  assign slow_clock_route_select = timer_mode_q[pwm12_pkg::SLOW_BIT];
  assign mode                    = timer_mode_q[pwm12_pkg::MODE_MSB:pwm12_pkg::MODE_LSB];
  assign pwm_mode                = mode == pwm12_pkg::MODE_PWM12;
  assign ppg_mode                = mode == pwm12_pkg::MODE_PPG16;
  assign running                 = run_q & (pwm_mode | ppg_mode);

  // Low-frequency pin: three stages, a rise counts once stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      lf_s1_q    <= 1'b0;
      lf_s2_q    <= 1'b0;
      lf_s3_q    <= 1'b0;
      lf_level_q <= 1'b0;
    end
    else
    begin
      lf_s1_q <= low_freq_clock;
      lf_s2_q <= lf_s1_q;
      lf_s3_q <= lf_s2_q;
      if (lf_s2_q == lf_s3_q)
        lf_level_q <= lf_s3_q;
    end
  end
  assign lf_edge = (lf_s2_q == lf_s3_q) & lf_s3_q & ~lf_level_q;
  // Free-running prescalers; a tick is the last count of the chosen power of two
  always_ff @(posedge core_clk)
  begin
    if (rst)
      gear_q <= 11'h000;
    else
      gear_q <= gear_q + 11'h001;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      slow_div_q <= 4'h0;
    else if (lf_edge)
      slow_div_q <= slow_div_q + 4'h1;
  end

  always_comb
  begin
    gear_exp = pwm12_pkg::GEAR_EXP_7;
    slow_exp = pwm12_pkg::SLOW_EXP_7;
    unique case (source_clock_select)
      3'h0: {gear_exp, slow_exp} = {pwm12_pkg::GEAR_EXP_0, pwm12_pkg::SLOW_EXP_0};
      3'h1: {gear_exp, slow_exp} = {pwm12_pkg::GEAR_EXP_1, pwm12_pkg::SLOW_EXP_1};
      3'h2: gear_exp = pwm12_pkg::GEAR_EXP_2;
      3'h3: gear_exp = pwm12_pkg::GEAR_EXP_3;
      3'h4: gear_exp = pwm12_pkg::GEAR_EXP_4;
      3'h5: gear_exp = pwm12_pkg::GEAR_EXP_5;
      3'h6: gear_exp = pwm12_pkg::GEAR_EXP_6;
      3'h7: gear_exp = pwm12_pkg::GEAR_EXP_7;
    endcase
  end
  // Only codes 000, 001 and 111 have a slow-clock source
  assign use_slow = slow_clock_route_select &
                    ((source_clock_select == 3'h0) | (source_clock_select == 3'h1) |
                     (source_clock_select == 3'h7));
  assign tick = use_slow ? (lf_edge & slow_tick(slow_div_q, slow_exp))
                         : gear_tick(gear_q, gear_exp);
  // Match evaluation runs every core cycle, so an equal value written mid-count
  // hits at once and may land off a source clock boundary
  assign duty_width          = {active_duty_q[11:8], active_duty_q[7:4]};
  assign extra_pulse_pattern = active_duty_q[3:0];
  assign pwm_target = {1'b0, duty_width} +
                      {8'h00, extra_here(extra_pulse_pattern, frame_q)};
  always_comb
  begin
    duty_hit   = 1'b0;
    period_end = 1'b0;
    if (running & pwm_mode)
    begin
      duty_hit   = ({1'b0, cnt_q[7:0]} == pwm_target) & ~dmatched_q;
      period_end = tick & (cnt_q[7:0] == pwm12_pkg::PWM_TOP);
    end
    else if (running & ppg_mode)
    begin
      duty_hit   = (cnt_q == active_duty_q) & ~dmatched_q;
      period_end = tick & (cnt_q == active_period_q);
    end
  end
  assign transfer = double_buffer_enable & period_end &
                    (ppg_mode | (frame_q == pwm12_pkg::FRAME_LAST));
  // Counter
  always_ff @(posedge core_clk)
  begin
    if (rst | ~running)
      cnt_q <= pwm12_pkg::CNT_RESET;
    else if (period_end)
      cnt_q <= pwm12_pkg::CNT_RESET;
    else if (tick)
      cnt_q <= cnt_q + 16'h0001;
  end

  // Overflow count within the sixteen-cycle frame
  always_ff @(posedge core_clk)
  begin
    if (rst | ~running)
      frame_q <= pwm12_pkg::FRAME_RESET;
    else if (period_end & pwm_mode)
      frame_q <= frame_q + 4'h1;
  end

  // One duty toggle per period; cleared at period end so a value below the
  // count waits for the next period
  always_ff @(posedge core_clk)
  begin
    if (rst | ~running | period_end)
      dmatched_q <= 1'b0;
    else if (duty_hit)
      dmatched_q <= 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      pwm_output_pin <= 1'b0;
    else if (~running | period_end)
      pwm_output_pin <= output_initial_level;
    else if (duty_hit)
      pwm_output_pin <= ~output_initial_level;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      overflow_irq      <= 1'b0;
      sixteen_cycle_irq <= 1'b0;
    end
    else
    begin
      overflow_irq      <= pwm_mode ? period_end : duty_hit;
      sixteen_cycle_irq <= period_end &
                           (ppg_mode | (frame_q == pwm12_pkg::FRAME_LAST));
    end
  end

  // Register writes
  assign commit = reg_wr & (reg_addr == pwm12_pkg::DUTY_HIGH_ADDR);
  assign direct = commit & ~(double_buffer_enable & running);

  always_ff @(posedge core_clk)
  begin
    if (rst)
      timer_mode_q <= pwm12_pkg::MODE_RESET;
    else if (reg_wr & (reg_addr == pwm12_pkg::MODE_ADDR) & ~run_q)
      timer_mode_q <= reg_wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      run_q <= 1'b0;
    else if (reg_wr & (reg_addr == pwm12_pkg::RUN_ADDR))
      run_q <= reg_wdata[pwm12_pkg::RUN_BIT];
  end

  // Low halves and the period high byte are only staged; nothing reaches the comparators before the duty high write
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      duty_low_q    <= pwm12_pkg::DUTY_RESET;
      period_low_q  <= pwm12_pkg::PERIOD_RESET;
      period_high_q <= pwm12_pkg::PERIOD_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == pwm12_pkg::DUTY_LOW_ADDR)
        duty_low_q <= reg_wdata;
      if (reg_addr == pwm12_pkg::PERIOD_LOW_ADDR)
        period_low_q <= reg_wdata;
      if (reg_addr == pwm12_pkg::PERIOD_HIGH_ADDR)
        period_high_q <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dbuf_duty_q   <= {pwm12_pkg::DUTY_RESET, pwm12_pkg::DUTY_RESET};
      dbuf_period_q <= {pwm12_pkg::PERIOD_RESET, pwm12_pkg::PERIOD_RESET};
    end
    else if (commit)
    begin
      dbuf_duty_q   <= {reg_wdata, duty_low_q};
      dbuf_period_q <= {period_high_q, period_low_q};
    end
  end

  // A direct write beats a transfer in the same cycle; the buffer copy is older
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      active_duty_q   <= {pwm12_pkg::DUTY_RESET, pwm12_pkg::DUTY_RESET};
      active_period_q <= {pwm12_pkg::PERIOD_RESET, pwm12_pkg::PERIOD_RESET};
    end
    else if (direct)
    begin
      active_duty_q   <= {reg_wdata, duty_low_q};
      active_period_q <= {period_high_q, period_low_q};
    end
    else if (transfer)
    begin
      active_duty_q   <= dbuf_duty_q;
      active_period_q <= dbuf_period_q;
    end
  end

  // Read port, data one cycle after the strobe, zero elsewhere
  always_ff @(posedge core_clk)
  begin
    if (rst | ~reg_rd)
      reg_rdata <= 8'h00;
    else
    begin
      unique case (reg_addr)
        pwm12_pkg::DUTY_LOW_ADDR:    reg_rdata <= dbuf_duty_q[7:0];
        pwm12_pkg::DUTY_HIGH_ADDR:   reg_rdata <= dbuf_duty_q[15:8];
        pwm12_pkg::MODE_ADDR:        reg_rdata <= timer_mode_q;
        pwm12_pkg::RUN_ADDR:         reg_rdata <= {7'h00, run_q};
        pwm12_pkg::PERIOD_LOW_ADDR:  reg_rdata <= dbuf_period_q[7:0];
        pwm12_pkg::PERIOD_HIGH_ADDR: reg_rdata <= dbuf_period_q[15:8];
        pwm12_pkg::STATUS_ADDR:
          reg_rdata <= {frame_q, 1'b0, dmatched_q, pwm_output_pin, running};
        default:                     reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> tb/pwm12_chk_asserts.sv
// Purpose: Port checker for the 12-bit PWM duty block
// Assumes: PWM12 and PPG16 modes, duty and mode written as the bench does
// Notes:   Helper state decodes register writes seen at the ports
`timescale 1ns/100ps
`default_nettype none
module pwm12_chk (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       low_freq_clock,
  input wire logic       pwm_output_pin,
  input wire logic       overflow_irq,
  input wire logic       sixteen_cycle_irq
);
  logic       run_q;
  logic       tff_q;
  logic [1:0] mode_q;
  logic [7:0] lo_st_q;
  logic [7:0] lo_q;
  logic [7:0] hi_q;
  logic [3:0] ovf_q;
  logic [8:0] gap_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      run_q <= 1'b0;
      tff_q <= 1'b0;
      mode_q <= 2'h0;
      lo_st_q <= 8'hFF;
      lo_q <= 8'hFF;
      hi_q <= 8'hFF;
    end
    else if (reg_wr)
    begin
      if (reg_addr == pwm12_pkg::RUN_ADDR)
        run_q <= reg_wdata[0];
      // Mode writes are dropped while running
      if (reg_addr == pwm12_pkg::MODE_ADDR && !run_q)
      begin
        tff_q  <= reg_wdata[pwm12_pkg::TFF_BIT];
        mode_q <= reg_wdata[pwm12_pkg::MODE_MSB:pwm12_pkg::MODE_LSB];
      end
      if (reg_addr == pwm12_pkg::DUTY_LOW_ADDR)
        lo_st_q <= reg_wdata;
      if (reg_addr == pwm12_pkg::DUTY_HIGH_ADDR)
      begin
        lo_q <= lo_st_q;
        hi_q <= reg_wdata;
      end
    end
  end
  // Frame and gap counters restart with every run write
  always_ff @(posedge core_clk)
  begin
    if (rst || (reg_wr && reg_addr == pwm12_pkg::RUN_ADDR))
    begin
      ovf_q <= 4'h0;
      gap_q <= 9'h1FF;
    end
    else if (overflow_irq)
    begin
      ovf_q <= ovf_q + 4'h1;
      gap_q <= 9'h000;
    end
    else if (gap_q != 9'h1FF)
      gap_q <= gap_q + 9'h001;
  end
  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its slot");
  a_read_duty_hi: assert property ($past(reg_rd) &&
    $past(reg_addr) == pwm12_pkg::DUTY_HIGH_ADDR |-> reg_rdata == hi_q)
    else $error("duty high read wrong");
  a_read_duty_lo: assert property ($past(reg_rd) &&
    $past(reg_addr) == pwm12_pkg::DUTY_LOW_ADDR |-> reg_rdata == lo_q)
    else $error("duty low read wrong");
  a_ovf_spacing: assert property (overflow_irq |-> gap_q >= 9'h0FF)
    else $error("overflows too close");
  a_sixteen_frame: assert property (mode_q == pwm12_pkg::MODE_PWM12 &&
    sixteen_cycle_irq |->
    overflow_irq && ovf_q == 4'hF)
    else $error("sixteen-cycle irq off frame");
  a_irq_pulse: assert property (overflow_irq |=> !overflow_irq)
    else $error("overflow irq too long");
  a_ovf_needs_run: assert property (overflow_irq |-> $past(run_q, 2))
    else $error("overflow while stopped");
  a_stop_level: assert property (!run_q && !$past(run_q) && $stable(tff_q)
    |-> pwm_output_pin == tff_q)
    else $error("stopped pin not at initial level");
  a_fall_at_ovf: assert property (run_q && $past(run_q) && !tff_q &&
    mode_q == pwm12_pkg::MODE_PWM12 &&
    $fell(pwm_output_pin) |-> (overflow_irq || $past(overflow_irq)) or ##1 overflow_irq)
    else $error("pin fell away from overflow");
  a_ppg_fall: assert property (mode_q == pwm12_pkg::MODE_PPG16 && run_q &&
    $past(run_q) && !tff_q && $fell(pwm_output_pin) |-> sixteen_cycle_irq)
    else $error("PPG pin fell away from period end");
endmodule
bind pwm12_duty_double_buffer pwm12_chk u_chk (
  .core_clk          (core_clk),
  .rst               (rst),
  .reg_addr          (reg_addr),
  .reg_wdata         (reg_wdata),
  .reg_wr            (reg_wr),
  .reg_rd            (reg_rd),
  .reg_rdata         (reg_rdata),
  .low_freq_clock    (low_freq_clock),
  .pwm_output_pin    (pwm_output_pin),
  .overflow_irq      (overflow_irq),
  .sixteen_cycle_irq (sixteen_cycle_irq)
);
`default_nettype wire

// >>> tb/pwm_load_model.sv
// Purpose: Load on the PWM pin that measures low pulse widths
// Assumes: Sampled on the core clock
// Notes:   A low span that crosses reset is not meaningful
`timescale 1ns/100ps
`default_nettype none
module pwm_load_model (
  input  wire logic        core_clk,
  input  wire logic        pin,
  output var  logic [15:0] low_len,
  output var  logic [15:0] rise_cnt
);
  logic [15:0] run_len = 16'h0000;
  logic        pin_q = 1'b0;
  initial
  begin
    low_len = 16'h0000;
    rise_cnt = 16'h0000;
  end
  always @(posedge core_clk)
  begin
    pin_q <= pin;
    if (pin === 1'b0)
      run_len <= run_len + 16'h0001;
    else if (pin === 1'b1 && pin_q === 1'b0)
    begin
      low_len <= run_len;
      rise_cnt <= rise_cnt + 16'h0001;
      run_len <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// >>> tb/pwm12_duty_double_buffer_test.sv
// Purpose: Self-checking bench for the 12-bit PWM duty block
// Assumes: Gear code 7 for duty checks, one tick per core cycle
// Notes:   Reference tracks effective duty from the bus writes
`timescale 1ns/100ps
`default_nettype none
module pwm12_duty_double_buffer_test;
  logic        core_clk;
  logic        rst;
  logic        reg_wr;
  logic        reg_rd;
  logic        lf;
  logic [7:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata;
  logic        pin;
  logic        ovf;
  logic        six;
  logic [15:0] low_len;
  logic [15:0] rise_cnt;
  logic [15:0] rise_p;
  logic [15:0] rc;
  logic        run_m, dbe_m, tff_m, mon;
  logic [7:0]  lo_m;
  logic [11:0] act_m, pend_m, v;
  logic [31:0] r;
  int          num_errors, tests_run, seed, ovf_n, g, n;
  logic [7:0]  md [5] = '{8'h47, 8'h46, 8'h45, 8'h44, 8'hC7};
  logic [15:0] cy [5] = '{16'h0100, 16'h0200, 16'h0400, 16'h1000, 16'h1800};
  pwm12_duty_double_buffer dut (
    .core_clk          (core_clk),
    .rst               (rst),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_wr            (reg_wr),
    .reg_rd            (reg_rd),
    .reg_rdata         (reg_rdata),
    .low_freq_clock    (lf),
    .pwm_output_pin    (pin),
    .overflow_irq      (ovf),
    .sixteen_cycle_irq (six)
  );
  pwm_load_model u_load (
    .core_clk (core_clk),
    .pin      (pin),
    .low_len  (low_len),
    .rise_cnt (rise_cnt)
  );
  function automatic logic [15:0] exp_low(logic [11:0] w, logic [3:0] f);
    logic x;
    x = (w[0] && f == 4'h8) || (w[1] && f[2:0] == 3'h4) || (w[2] && f[1:0] == 2'h2)
      || (w[3] && f[0]);
    return {8'h00, w[11:4]} + 16'h0001 + {15'h0000, x};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic rd, input logic [7:0] a, input logic [7:0] d);
    reg_wr <= w;
    reg_rd <= rd;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, 1'b1, a, 8'h00);
    bus(1'b0, 1'b0, a, 8'h00);
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  // Low before high, back to back, so the high write commits both
  task automatic set_duty(input logic [11:0] w);
    bus(1'b1, 1'b0, pwm12_pkg::DUTY_LOW_ADDR, w[7:0]);
    bus(1'b1, 1'b0, pwm12_pkg::DUTY_HIGH_ADDR, {4'h0, w[11:8]});
    bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic wait_ovf(output int k);
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (ovf !== 1'b1 && k < 30000);
    if (k >= 30000)
      num_errors++;
  endtask
  task automatic rnd_duty;
    r = $random(seed);
    v = {8'h08 + {1'b0, r[6:0]}, r[11:8]};
  endtask
  task automatic results;
    $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    rise_p <= rise_cnt;
    if (reg_wr && reg_addr == pwm12_pkg::MODE_ADDR && !run_m)
      {dbe_m, tff_m} <= {reg_wdata[3], reg_wdata[4]};
    if (reg_wr && reg_addr == pwm12_pkg::DUTY_LOW_ADDR)
      lo_m <= reg_wdata;
    if (reg_wr && reg_addr == pwm12_pkg::DUTY_HIGH_ADDR)
    begin
      pend_m <= {reg_wdata[3:0], lo_m};
      if (!dbe_m || !run_m)
        act_m <= {reg_wdata[3:0], lo_m};
    end
    if (six && dbe_m)
      act_m <= pend_m;
    if (ovf)
      ovf_n <= ovf_n + 1;
    if (reg_wr && reg_addr == pwm12_pkg::RUN_ADDR)
    begin
      run_m <= reg_wdata[0];
      ovf_n <= 0;
    end
    if (mon && !tff_m && rise_cnt !== rise_p && ovf_n > 0)
      chk(low_len, exp_low(act_m, ovf_n[3:0]));
  end
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Slow clock pin, unrelated in phase to the core clock
  initial
  begin
    lf = 1'b0;
    #3;
    forever #30 lf = ~lf;
  end
  initial
  begin
    #1_000_000;
    num_errors++;
    results;
  end
  initial
  begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 18'h0_0000};
    {run_m, dbe_m, tff_m, mon, lo_m} = {4'h0, 8'hFF};
    {act_m, pend_m, rise_p} = {24'hFFF_FFF, 16'h0000};
    {num_errors, tests_run, ovf_n, seed} = {32'h0, 32'h0, 32'h0, 32'h02f3};
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rd(pwm12_pkg::DUTY_LOW_ADDR, 8'hFF);
    rd(pwm12_pkg::DUTY_HIGH_ADDR, 8'hFF);
    rd(8'h30, 8'h00);
    chk({15'h0000, pin}, 16'h0000);
    wr(pwm12_pkg::MODE_ADDR, 8'h4F);
    set_duty(12'h138);
    wr(pwm12_pkg::DUTY_LOW_ADDR, 8'hA5);
    rd(pwm12_pkg::DUTY_LOW_ADDR, 8'h38);
    set_duty(12'h138);
    mon <= 1'b1;
    wr(pwm12_pkg::RUN_ADDR, 8'h01);
    repeat (17) wait_ovf(g);
    repeat (3)
    begin
      rnd_duty;
      wait_ovf(g);
      set_duty(v);
      rd(pwm12_pkg::DUTY_HIGH_ADDR, {4'h0, v[11:8]});
      repeat (20) wait_ovf(g);
    end
    wr(pwm12_pkg::RUN_ADDR, 8'h00);
    repeat (2) @(posedge core_clk);
    chk({15'h0000, pin}, 16'h0000);
    wr(pwm12_pkg::MODE_ADDR, 8'h47);
    wr(pwm12_pkg::RUN_ADDR, 8'h01);
    repeat (3)
    begin
      rnd_duty;
      wait_ovf(g);
      set_duty(v);
      repeat (3) wait_ovf(g);
    end
    set_duty(12'hC80);
    wait_ovf(g);
    repeat (100) @(posedge core_clk);
    mon <= 1'b0;
    rc = rise_cnt;
    set_duty(12'h320);
    wait_ovf(g);
    chk(rise_cnt, rc);
    repeat (2) wait_ovf(g);
    mon <= 1'b1;
    repeat (3) wait_ovf(g);
    // The high write lands while the count reads 3, so the match is taken at once
    wait_ovf(g);
    set_duty(12'h030);
    repeat (2) @(posedge core_clk);
    chk(low_len, 16'h0004);
    mon <= 1'b0;
    wr(pwm12_pkg::RUN_ADDR, 8'h00);
    wr(pwm12_pkg::MODE_ADDR, 8'h57);
    repeat (2) @(posedge core_clk);
    chk({15'h0000, pin}, 16'h0001);
    wr(pwm12_pkg::RUN_ADDR, 8'h01);
    wr(pwm12_pkg::MODE_ADDR, 8'h47);
    wait_ovf(g);
    wr(pwm12_pkg::RUN_ADDR, 8'h00);
    repeat (2) @(posedge core_clk);
    chk({15'h0000, pin}, 16'h0001);
    for (int i = 0; i < 5; i++)
    begin
      wr(pwm12_pkg::RUN_ADDR, 8'h00);
      wr(pwm12_pkg::MODE_ADDR, md[i]);
      wr(pwm12_pkg::RUN_ADDR, 8'h01);
      wait_ovf(g);
      wait_ovf(n);
      chk(n[15:0], cy[i]);
    end
    // PPG with period 0x0200 and duty 0x0100: the low span is duty plus one
    wr(pwm12_pkg::RUN_ADDR, 8'h00);
    wr(pwm12_pkg::MODE_ADDR, 8'h67);
    wr(pwm12_pkg::PERIOD_LOW_ADDR, 8'h00);
    wr(pwm12_pkg::PERIOD_HIGH_ADDR, 8'h02);
    set_duty(12'h100);
    wr(pwm12_pkg::RUN_ADDR, 8'h01);
    repeat (2) wait_ovf(g);
    repeat (2) @(posedge core_clk);
    chk(low_len, 16'h0101);
    results;
  end
endmodule
`default_nettype wire
